// *** smc_pkg.sv ***
// Contract
// - Any stop depth halts the system clock to every peripheral module.
// - With debug entry enabled the debug clock runs in stop; peripherals still halt.
// - Shallow stop leaves pins unchanged, driven by retained logic.
// - Retention stop latches all pin states before the stop takes effect; the code raises pin_hold one cycle after cpu_stopped.
// - Deepest stop forces every pin to its reset state on entry.
// - Shallow stop keeps all RAM and register contents.
// - Retention wake resets registers, keeps RAM, holds pin latches until acknowledge.
// - Deepest wake resets registers and marks RAM lost.
// - Flash contents are kept in every stop depth.
// - Shallow stop puts clock generator in standby; oscillator or reference may stay; the code drops cg_standby when debug entry is enabled.
// - Deeper stops turn the clock generator fully off regardless of keep bits.
// - Both timers halt in stop and reset on deeper wake.
// - Converter goes standby, starts no conversion, resets on deeper wake.
// - Enabled keyboard pins wake from shallow; keyboard disabled and reset otherwise.
// - Wake timer runs in shallow and retention, off in deepest; clock source per depth.
// - With debug enabled the internal low-rate wake clock does not run.
// - Serial, SPI and two-wire modules halt in stop and reset on deeper wake.
// - Regulator standby in stop unless low-voltage-in-stop or debug is enabled.
// - Deeper depth requested with debug enabled enters shallow stop instead.
// - Retention wake sets recovery flag, held until acknowledge is written.
// - Rate select zero disables wake timer and its internal low-rate source.
//
// Package of the stop-mode controller: register map, field layout and carriers.
// Assumes a 32-bit AXI4-Lite master and one clock domain.
package smc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ACK = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ACK_RELEASE_BIT = 0;
    localparam int ST_DEPTH_LSB = 0;
    localparam int ST_IN_STOP = 2;
    localparam int ST_RECOVERY = 3;
    localparam int ST_PINS_LATCHED = 4;
    localparam int ST_RAM_LOST = 5;
    localparam int ST_REG_STANDBY = 6;

    // ------------------------------------------------------------
    // Stop depths and control layout
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEP_SHALLOW = 2'h0,
        DEP_RETENTION = 2'h1,
        DEP_DEEPEST = 2'h2
    } smc_depth_t;

    // Bit 0..1 depth, 2 oscillator keep, 3 reference keep, 4 low-voltage in stop,
    // 5 debug entry enable, 6 wake timer on external clock, 8..10 wake rate select.
    typedef struct packed {
        logic [2:0] wake_rate_select;
        logic rsvd;
        logic rti_use_ext;
        logic debug_entry_enable;
        logic lvd_stop_en;
        logic ref_keep;
        logic osc_keep;
        smc_depth_t depth;
    } smc_ctrl_t;
    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

    // ------------------------------------------------------------
    // Peripheral indices
    // ------------------------------------------------------------
    localparam int PER_N = 8;
    localparam int PER_TMR0 = 0;
    localparam int PER_TMR1 = 1;
    localparam int PER_ADC = 2;
    localparam int PER_UART0 = 3;
    localparam int PER_UART1 = 4;
    localparam int PER_SPI = 5;
    localparam int PER_I2C = 6;
    localparam int PER_KBD = 7;

    // Wake timer period in low-rate ticks is RTI_BASE shifted left by rate select.
    localparam int RTI_BASE = 8;
    localparam int RTI_CNT_W = 16;

    typedef struct packed {
        logic [PER_N-1:0] periph_clk_en;
        logic [PER_N-1:0] periph_rst;
        logic dbg_clk_en;
        logic pin_hold;
        logic pin_force_reset;
        logic ram_retain;
        logic flash_retain;
        logic cg_standby;
        logic cg_off;
        logic osc_keep;
        logic ref_keep;
        logic reg_standby;
        logic adc_standby;
        logic kbd_en;
        logic rti_osc_en;
        logic rti_en;
        logic cpu_stopped;
        logic sys_rst;
    } smc_pwr_t;
endpackage

// *** smc_stop_ctrl.sv ***
// Stop-mode controller: depth selection, clock gating, pin hold and wake handling.
// Assumes stop_req comes from core logic on mclk and pins arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none
module smc_stop_ctrl #(
    parameter int KBD_W = 8,
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic stop_req,
    input wire logic dbg_wake,
    input wire logic irq_wake_n,
    input wire logic [KBD_W-1:0] kbd_pins,
    input wire logic [KBD_W-1:0] kbd_pin_en,
    input wire logic lpo_clk_in,
    input wire logic ext_clk_in,
    output logic rti_wake,
    output smc_pkg::smc_pwr_t pwr,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_STOP,
        ST_WAKE
    } smc_fsm_t;

    typedef struct packed {
        smc_fsm_t fsm;
        smc_pkg::smc_ctrl_t ctrl;
        smc_pkg::smc_depth_t act_depth;
        logic act_dbg;
        logic act_lvd;
        logic act_ext;
        logic recovery;
        logic pins_latched;
        logic ram_lost;
        logic irq_s1;
        logic irq_s2;
        logic [KBD_W-1:0] kbd_s1;
        logic [KBD_W-1:0] kbd_s2;
        logic lpo_s1;
        logic lpo_s2;
        logic lpo_s3;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic [smc_pkg::RTI_CNT_W-1:0] rti_cnt;
        logic rti_pulse;
        smc_pkg::smc_pwr_t pwr;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } smc_state_t;

    smc_state_t st_r;
    smc_state_t st_nxt;

    localparam int CTRL_W = smc_pkg::CTRL_W;
    localparam int RTI_CNT_W = smc_pkg::RTI_CNT_W;

    // Word-aligned register decode, shared by the read and write paths.
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w = 8'(a) & 8'hfc;
        if (w == smc_pkg::OFS_CTRL)
            reg_sel = 2'd1;
        else if (w == smc_pkg::OFS_STATUS)
            reg_sel = 2'd2;
        else if (w == smc_pkg::OFS_ACK)
            reg_sel = 2'd3;
        else
            reg_sel = 2'd0;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic stopped;
        logic deeper;
        logic rate_on;
        logic int_src_on;
        logic tick;
        logic [smc_pkg::RTI_CNT_W-1:0] rti_top;
        logic wake;
        logic wr_go;
        logic ack_wr;
        logic [31:0] status;
        smc_pkg::smc_depth_t req_depth;
        smc_pkg::smc_ctrl_t cw;
        smc_pkg::smc_pwr_t p;
        stopped = 1'b0;
        deeper = 1'b0;
        rate_on = 1'b0;
        int_src_on = 1'b0;
        tick = 1'b0;
        rti_top = '0;
        wake = 1'b0;
        wr_go = 1'b0;
        ack_wr = 1'b0;
        status = '0;
        req_depth = smc_pkg::DEP_SHALLOW;
        cw = st_r.ctrl;
        p = '0;
        st_nxt = st_r;

        // Pin synchronisers; logic reads the second stage, and the third for slow-clock edges.
        st_nxt.irq_s1 = irq_wake_n;
        st_nxt.irq_s2 = st_r.irq_s1;
        st_nxt.kbd_s1 = kbd_pins;
        st_nxt.kbd_s2 = st_r.kbd_s1;
        st_nxt.lpo_s1 = lpo_clk_in;
        st_nxt.lpo_s2 = st_r.lpo_s1;
        st_nxt.lpo_s3 = st_r.lpo_s2;
        st_nxt.ext_s1 = ext_clk_in;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;

        stopped = (st_r.fsm == ST_ENTER) || (st_r.fsm == ST_STOP);
        deeper = st_r.act_depth != smc_pkg::DEP_SHALLOW;

        // Wake timer: source choice depends on the active depth.
        rate_on = st_r.ctrl.wake_rate_select != 3'h0;
        int_src_on = rate_on && !(stopped && st_r.act_dbg)
            && !(stopped && st_r.act_depth == smc_pkg::DEP_DEEPEST);
        if (stopped && st_r.act_depth == smc_pkg::DEP_RETENTION)
            tick = int_src_on && st_r.lpo_s2 && !st_r.lpo_s3;
        else if (stopped ? st_r.act_ext : st_r.ctrl.rti_use_ext)
            tick = st_r.ext_s2 && !st_r.ext_s3;
        else
            tick = int_src_on && st_r.lpo_s2 && !st_r.lpo_s3;
        if (stopped && st_r.act_depth == smc_pkg::DEP_DEEPEST)
            tick = 1'b0;
        rti_top = RTI_CNT_W'(smc_pkg::RTI_BASE << st_r.ctrl.wake_rate_select) - 1'b1;
        st_nxt.rti_pulse = 1'b0;
        if (!rate_on)
            st_nxt.rti_cnt = '0;
        else if (tick)
        begin
            if (st_r.rti_cnt >= rti_top)
            begin
                st_nxt.rti_cnt = '0;
                st_nxt.rti_pulse = 1'b1;
            end
            else
                st_nxt.rti_cnt = st_r.rti_cnt + 1'b1;
        end

        // Wake sources allowed per depth.
        wake = !st_r.irq_s2;
        if (st_r.act_depth != smc_pkg::DEP_DEEPEST && st_r.rti_pulse)
            wake = 1'b1;
        if (st_r.act_depth == smc_pkg::DEP_SHALLOW && |(st_r.kbd_s2 & kbd_pin_en))
            wake = 1'b1;
        if (st_r.act_depth == smc_pkg::DEP_SHALLOW && st_r.act_dbg && dbg_wake)
            wake = 1'b1;

        // Write path, taken once both address and data have arrived.
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        wr_go = st_r.aw_got && st_r.w_got && !st_r.bvalid;
        if (wr_go)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = smc_pkg::RESP_OKAY;
            if (reg_sel(st_r.awaddr) == 2'd1)
            begin
                if (st_r.wstrb[0])
                    cw[7:0] = st_r.wdata[7:0];
                if (st_r.wstrb[1])
                    cw[CTRL_W-1:8] = st_r.wdata[CTRL_W-1:8];
                cw.rsvd = 1'b0;
                st_nxt.ctrl = cw;
            end
            else if (reg_sel(st_r.awaddr) == 2'd3)
                ack_wr = st_r.wstrb[0] && st_r.wdata[smc_pkg::ACK_RELEASE_BIT];
            else if (reg_sel(st_r.awaddr) == 2'd0)
                st_nxt.bresp = smc_pkg::RESP_SLVERR;
        end
        // Acknowledge opens the pin latches and clears recovery; a wake or entry in the
        // same cycle sets recovery or the pin latches again below, so the set wins.
        if (ack_wr)
        begin
            st_nxt.recovery = 1'b0;
            st_nxt.pins_latched = 1'b0;
            st_nxt.ram_lost = 1'b0;
        end

        // Read path, answered one cycle after the address is taken.
        status[smc_pkg::ST_DEPTH_LSB +: 2] = st_r.act_depth;
        status[smc_pkg::ST_IN_STOP] = stopped;
        status[smc_pkg::ST_RECOVERY] = st_r.recovery;
        status[smc_pkg::ST_PINS_LATCHED] = st_r.pins_latched;
        status[smc_pkg::ST_RAM_LOST] = st_r.ram_lost;
        status[smc_pkg::ST_REG_STANDBY] = st_r.pwr.reg_standby;
        if (st_r.rvalid && s_axi_rready)
            st_nxt.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = smc_pkg::RESP_OKAY;
            st_nxt.rdata = '0;
            if (reg_sel(s_axi_araddr) == 2'd1)
                st_nxt.rdata = 32'(st_r.ctrl);
            else if (reg_sel(s_axi_araddr) == 2'd2)
                st_nxt.rdata = status;
            else if (reg_sel(s_axi_araddr) == 2'd3)
                st_nxt.rdata = '0;
            else
                st_nxt.rresp = smc_pkg::RESP_SLVERR;
        end

        // Sequencer.
        case (st_r.fsm)
            ST_RUN:
            begin
                if (stop_req)
                begin
                    // Freeze the depth and enables for the whole stop period.
                    req_depth = st_r.ctrl.depth;
                    if (req_depth != smc_pkg::DEP_RETENTION)
                        req_depth = (req_depth == smc_pkg::DEP_SHALLOW) ?
                            smc_pkg::DEP_SHALLOW : smc_pkg::DEP_DEEPEST;
                    if (st_r.ctrl.debug_entry_enable || st_r.ctrl.lvd_stop_en)
                        req_depth = smc_pkg::DEP_SHALLOW;
                    st_nxt.act_depth = req_depth;
                    st_nxt.act_dbg = st_r.ctrl.debug_entry_enable;
                    st_nxt.act_lvd = st_r.ctrl.lvd_stop_en;
                    st_nxt.act_ext = st_r.ctrl.rti_use_ext;
                    st_nxt.fsm = ST_ENTER;
                end
            end
            ST_ENTER:
            begin
                // Pins are captured here, one cycle after the stop is in force.
                if (st_r.act_depth == smc_pkg::DEP_RETENTION)
                    st_nxt.pins_latched = 1'b1;
                st_nxt.fsm = ST_STOP;
            end
            ST_STOP:
            begin
                if (wake)
                    st_nxt.fsm = deeper ? ST_WAKE : ST_RUN;
            end
            default:
            begin
                // Register state is lost on deeper wake; latched pins are not.
                st_nxt.ctrl = smc_pkg::CTRL_RST;
                st_nxt.act_depth = smc_pkg::DEP_SHALLOW;
                st_nxt.act_dbg = 1'b0;
                st_nxt.act_lvd = 1'b0;
                st_nxt.act_ext = 1'b0;
                st_nxt.rti_cnt = '0;
                if (st_r.act_depth == smc_pkg::DEP_RETENTION)
                    st_nxt.recovery = 1'b1;
                else
                    st_nxt.ram_lost = 1'b1;
                st_nxt.fsm = ST_RUN;
            end
        endcase

        // Power outputs, computed from the next state so they leave flip-flops.
        stopped = (st_nxt.fsm == ST_ENTER) || (st_nxt.fsm == ST_STOP);
        p.periph_clk_en = stopped ? '0 : '1;
        p.periph_rst = (st_nxt.fsm == ST_WAKE) ? '1 : '0;
        p.sys_rst = st_nxt.fsm == ST_WAKE;
        p.dbg_clk_en = !stopped || st_nxt.act_dbg;
        p.pin_hold = st_nxt.pins_latched;
        p.pin_force_reset = stopped && st_nxt.act_depth == smc_pkg::DEP_DEEPEST;
        p.ram_retain = !(stopped && st_nxt.act_depth == smc_pkg::DEP_DEEPEST);
        p.flash_retain = 1'b1;
        if (stopped && st_nxt.act_depth == smc_pkg::DEP_SHALLOW)
        begin
            p.cg_standby = !st_nxt.act_dbg;
            p.osc_keep = st_nxt.ctrl.osc_keep || st_nxt.act_dbg;
            p.ref_keep = st_nxt.ctrl.ref_keep || st_nxt.act_dbg;
        end
        else if (stopped)
            p.cg_off = 1'b1;
        p.reg_standby = stopped && !st_nxt.act_lvd && !st_nxt.act_dbg;
        p.adc_standby = stopped;
        p.kbd_en = !(stopped && st_nxt.act_depth != smc_pkg::DEP_SHALLOW);
        p.rti_en = (st_nxt.ctrl.wake_rate_select != 3'h0)
            && !(stopped && st_nxt.act_depth == smc_pkg::DEP_DEEPEST);
        p.rti_osc_en = p.rti_en && !(stopped && st_nxt.act_dbg);
        p.cpu_stopped = stopped;
        st_nxt.pwr = p;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '0;
            st_r.fsm <= ST_RUN;
            st_r.irq_s1 <= 1'b1;
            st_r.irq_s2 <= 1'b1;
            st_r.pwr.periph_clk_en <= '1;
            st_r.pwr.dbg_clk_en <= 1'b1;
            st_r.pwr.ram_retain <= 1'b1;
            st_r.pwr.flash_retain <= 1'b1;
            st_r.pwr.kbd_en <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pwr = st_r.pwr;
    assign rti_wake = st_r.rti_pulse;
    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
endmodule
`default_nettype wire

// *** smc_stop_ctrl_monitor.sv ***
// Checker of the stop-mode controller, bound to its top module.
// Assumes one clock domain and the pwr carrier of smc_pkg.
`timescale 1ns/10ps
`default_nettype none
module smc_stop_ctrl_monitor (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic stop_req,
    input wire logic s_axi_bvalid,
    input wire smc_pkg::smc_pwr_t pwr
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence s_run_req;
        !pwr.cpu_stopped && !pwr.sys_rst && stop_req;
    endsequence
    sequence s_gated;
        pwr.cpu_stopped && pwr.periph_clk_en == '0;
    endsequence
    sequence s_wake_pulse;
        pwr.periph_rst == '1 ##1 !pwr.sys_rst && pwr.periph_rst == '0;
    endsequence
    property p_entry;
        s_run_req |=> s_gated;
    endproperty
    property p_gate;
        pwr.cpu_stopped && !pwr.sys_rst |-> pwr.periph_clk_en == '0;
    endproperty
    property p_force;
        pwr.pin_force_reset |-> pwr.cpu_stopped && !pwr.pin_hold;
    endproperty
    property p_cg_off;
        pwr.cg_off |-> !pwr.osc_keep && !pwr.ref_keep;
    endproperty
    property p_flash;
        pwr.flash_retain;
    endproperty
    property p_wake_rst;
        $rose(pwr.sys_rst) |-> s_wake_pulse;
    endproperty
    property p_rst_only_wake;
        pwr.periph_rst != '0 |-> pwr.sys_rst;
    endproperty
    property p_latch_rel;
        $fell(pwr.pin_hold) |-> $rose(s_axi_bvalid);
    endproperty
    property p_deep_off;
        pwr.pin_force_reset |-> !pwr.kbd_en && !pwr.rti_en && pwr.cg_off;
    endproperty
    property p_reg;
        pwr.reg_standby |-> pwr.cpu_stopped;
    endproperty
    a_entry: assert property (p_entry)
        else $error("stop entry left peripheral clocks running");
    a_gate: assert property (p_gate)
        else $error("peripheral clock on while stopped");
    a_force: assert property (p_force)
        else $error("pin reset forced outside deepest stop");
    a_cg_off: assert property (p_cg_off)
        else $error("oscillator kept while clock generator off");
    a_flash: assert property (p_flash)
        else $error("flash retention dropped");
    a_wake_rst: assert property (p_wake_rst)
        else $error("wake reset pulse malformed");
    a_rst_only_wake: assert property (p_rst_only_wake)
        else $error("peripheral reset outside wake");
    a_latch_rel: assert property (p_latch_rel)
        else $error("pin latch opened without acknowledge write");
    a_deep_off: assert property (p_deep_off)
        else $error("unit left on in deepest stop");
    a_reg: assert property (p_reg)
        else $error("regulator standby while running");
endmodule

bind smc_stop_ctrl smc_stop_ctrl_monitor i_mon (.mclk, .arst_n, .stop_req, .s_axi_bvalid, .pwr);
`default_nettype wire

// *** smc_far_model.sv ***
// Far-side model: the slow clocks that the wake timer counts.
// Assumes mclk is the fast system clock; both slow clocks are divided from it.
`timescale 1ns/10ps
`default_nettype none
module smc_far_model #(
    parameter int LPO_HALF = 6,
    parameter int EXT_HALF = 4
) (
    input wire logic mclk,
    input wire logic arst_n,
    output logic lpo_clk_in,
    output logic ext_clk_in
);
    int lpo_cnt_r;
    int ext_cnt_r;
    // The real low-rate source is far slower; short half periods keep runs brief.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lpo_cnt_r <= 0;
            ext_cnt_r <= 0;
            lpo_clk_in <= 1'h0;
            ext_clk_in <= 1'h0;
        end
        else
        begin
            lpo_cnt_r <= (lpo_cnt_r == LPO_HALF - 1) ? 0 : lpo_cnt_r + 1;
            ext_cnt_r <= (ext_cnt_r == EXT_HALF - 1) ? 0 : ext_cnt_r + 1;
            lpo_clk_in <= lpo_clk_in ^ (lpo_cnt_r == LPO_HALF - 1);
            ext_clk_in <= ext_clk_in ^ (ext_cnt_r == EXT_HALF - 1);
        end
    end
endmodule
`default_nettype wire

// *** smc_stop_ctrl_bench.sv ***
// Self-checking bench of the stop-mode controller over AXI4-Lite.
// Assumes the far-side model supplies both slow clocks.
`timescale 1ns/10ps
`default_nettype none
module smc_stop_ctrl_bench;
    logic mclk, arst_n, stop_req, dbg_wake, irq_wake_n, rti_wake, lpo_clk_in, ext_clk_in;
    logic [7:0] kbd_pins, kbd_pin_en, s_axi_awaddr, s_axi_araddr, rst_seen;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    smc_pkg::smc_pwr_t pwr;
    int error_cnt, check_count, cyc;
    logic [10:0] cf [5] = '{11'h004, 11'h001, 11'h00e, 11'h122, 11'h111};
    logic [5:0] ex [5] = '{6'h06, 6'h2c, 6'h1c, 6'h02, 6'h03};
    logic [2:0] st [5] = '{3'h0, 3'h3, 3'h4, 3'h0, 3'h0};

    smc_stop_ctrl i_dut (.mclk, .arst_n, .stop_req, .dbg_wake, .irq_wake_n, .kbd_pins,
        .kbd_pin_en, .lpo_clk_in, .ext_clk_in, .rti_wake, .pwr, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    smc_far_model i_far (.mclk, .arst_n, .lpo_clk_in, .ext_clk_in);

    initial
    begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("[ERR] %0t run timed out", $time);
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        done = 1'h0;
        while (!done)
        begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            done = s_axi_bvalid;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic enter(input logic [10:0] c);
        axi_wr(smc_pkg::OFS_CTRL, {21'h0, c}, rs);
        @(posedge mclk);
        stop_req <= 1'h1;
        @(posedge mclk);
        stop_req <= 1'h0;
        repeat (2) @(posedge mclk);
        #1;
        chk(pwr.cpu_stopped, 1'h1);
        chk(pwr.periph_clk_en, 8'h00);
    endtask
    task automatic wait_run(output logic [7:0] seen);
        seen = 8'h00;
        do
        begin
            @(posedge mclk);
            #1;
            if (pwr.sys_rst || rti_wake) seen = pwr.periph_rst | 8'(rti_wake);
        end while (pwr.cpu_stopped || pwr.sys_rst);
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        {stop_req, dbg_wake, s_axi_awvalid, s_axi_wvalid, s_axi_bready, kbd_pins} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {error_cnt, check_count} = '0;
        s_axi_wstrb = 4'hf;
        kbd_pin_en = 8'h01;
        irq_wake_n = 1'h1;
        arst_n = 1'h0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'h1;
        #1;
        chk(pwr.periph_clk_en, 8'hff);
        axi_rd(smc_pkg::OFS_CTRL, rd, rs);
        chk(rd, 32'h0);
        axi_rd(8'h0c, rd, rs);
        chk({rs, rd}, {smc_pkg::RESP_SLVERR, 32'h0});
        axi_wr(8'h0c, 32'h0000_00ff, rs);
        chk(rs, smc_pkg::RESP_SLVERR);
        $display("register access done");
        for (int i = 0; i < 5; i++)
        begin
            enter(cf[i]);
            chk({pwr.pin_hold, pwr.pin_force_reset, pwr.cg_off, pwr.reg_standby, pwr.kbd_en,
                pwr.rti_osc_en}, ex[i]);
            chk(pwr.ram_retain, !st[i][2]);
            chk({pwr.cg_standby, pwr.adc_standby}, {st[i] == 3'h0 && !cf[i][5], 1'h1});
            @(posedge mclk);
            if (cf[i][5])
            begin
                chk(pwr.dbg_clk_en, 1'h1);
                dbg_wake <= 1'h1;
                @(posedge mclk);
                dbg_wake <= 1'h0;
            end
            else
            begin
                chk(pwr.osc_keep, cf[i] == 11'h004);
                irq_wake_n <= 1'h0;
            end
            wait_run(rst_seen);
            @(posedge mclk);
            irq_wake_n <= 1'h1;
            chk(rst_seen, st[i] != 3'h0 ? 8'hff : 8'h00);
            repeat (4) @(posedge mclk);
            axi_rd(smc_pkg::OFS_STATUS, rd, rs);
            chk(rd[6:0], {1'h0, st[i], 3'h0});
            axi_rd(smc_pkg::OFS_CTRL, rd, rs);
            chk(rd, st[i] != 3'h0 ? 32'h0 : {21'h0, cf[i]});
            chk(pwr.pin_hold, st[i][0]);
            axi_wr(smc_pkg::OFS_ACK, 32'h0000_0001, rs);
            #1;
            chk(pwr.pin_hold, 1'h0);
            axi_rd(smc_pkg::OFS_STATUS, rd, rs);
            chk(rd[6:0], 7'h0);
            $display("depth case %0d done", i);
        end
        enter(11'h000);
        @(posedge mclk);
        kbd_pins <= 8'h02;
        repeat (8) @(posedge mclk);
        #1;
        chk(pwr.cpu_stopped, 1'h1);
        @(posedge mclk);
        kbd_pins <= 8'h01;
        wait_run(rst_seen);
        chk(rst_seen, 8'h00);
        @(posedge mclk);
        kbd_pins <= 8'h00;
        $display("keyboard wake done");
        enter(11'h140);
        chk(pwr.rti_en, 1'h1);
        wait_run(rst_seen);
        chk(rst_seen, 8'h01);
        $display("wake timer done");
        summarize();
    end
endmodule
`default_nettype wire
